/* rtl/ccid_exec.sv */
// Execution slice: compare-branch, clear, invert, BCD fix, subtract one.
// Assumes the core presents fetched bytes and operands with a one-cycle
// issue strobe and applies the registered result when done is high.
`timescale 1ns/1ns
module ccid_exec (
  input  wire logic                  clock_i,   // Core clock, 10 MHz
  input  wire logic                  rst_i,     // Synchronous reset
  input  wire logic                  issue_i,   // Instruction presented
  input  wire ccid_pkg::ccid_instr_t instr_i,   // Instruction bytes and address
  input  wire ccid_pkg::ccid_ctx_t   ctx_i,     // Accumulator and flags
  input  wire logic [7:0]            operand_i, // Byte read at the operand address
  input  wire logic [7:0]            latch_i,   // Port output latch at that address
  input  wire logic                  is_port_i, // Operand address is a port
  input  wire logic                  bit_i,     // Addressed bit as read
  input  wire logic                  bit_latch_i, // Addressed bit's port latch
  output logic                       busy_o,    // Compare in progress
  output ccid_pkg::ccid_res_t        res_o      // Registered result
);

  // ********************************
  // State and result registers
  // ********************************
  ccid_pkg::ccid_state_t state_q;  // Sequencer state
  ccid_pkg::ccid_state_t state_d;  // Next state
  ccid_pkg::ccid_res_t   res_q;    // Result flops
  ccid_pkg::ccid_res_t   res_d;    // Next result
  logic                  busy_q;   // Busy flop
  logic                  take_q;   // Compare found a difference
  logic                  lt_q;     // Compare found first below second
  logic [15:0]           fall_q;   // Address after the compare
  logic [15:0]           tgt_q;    // Branch target

  // ********************************
  // Decode
  // ********************************
  wire [7:0] op   = instr_i.opcode;     // Opcode byte
  wire       go   = issue_i & (state_q == ccid_pkg::CCID_IDLE); // Accepted
  wire       cmp  = (op[7:4] == ccid_pkg::CMP_HI) & (op[3:2] != 2'b00);
  wire       c_im = op[3:0] == ccid_pkg::CMP_IMM; // Accumulator vs immediate
  wire       c_dr = op[3:0] == ccid_pkg::CMP_DIR; // Accumulator vs direct
  wire       c_in = op[3:1] == ccid_pkg::CMP_IND; // Pointer vs immediate
  wire       clr_a = op == ccid_pkg::OP_CLR_A;    // Zero fill accumulator
  wire       clr_c = op == ccid_pkg::OP_CLR_C;    // Zero fill carry
  wire       clr_b = op == ccid_pkg::OP_CLR_BIT;  // Zero fill bit
  wire       inv_a = op == ccid_pkg::OP_INV_A;    // Invert accumulator
  wire       inv_c = op == ccid_pkg::OP_INV_C;    // Invert carry
  wire       inv_b = op == ccid_pkg::OP_INV_BIT;  // Invert bit
  wire       bcd   = op == ccid_pkg::OP_BCD;      // BCD nibble fix
  wire       dec_a = op == ccid_pkg::OP_DEC_A;    // Subtract one, accumulator
  wire       dec_d = op == ccid_pkg::OP_DEC_DIR;  // Subtract one, direct
  wire       dec_i = op[7:1] == ccid_pkg::OP_DEC_IND[7:1]; // Pointer form
  wire       dec_r = op[7:3] == ccid_pkg::OP_DEC_REG[7:3]; // Register form
  wire       dec_m = dec_d | dec_i | dec_r;       // Subtract one in memory
  wire       one   = clr_a | clr_c | clr_b | inv_a | inv_c | inv_b | bcd
                     | dec_a | dec_m;             // Single-cycle opcodes
  wire       unk   = ~one & ~cmp;                 // Not in this slice

  // ********************************
  // Compare datapath
  // ********************************
  // operand selection per form
  wire [7:0]  cmp_a  = (c_im | c_dr) ? ctx_i.acc : operand_i; // First operand
  wire [7:0]  cmp_b  = c_dr ? operand_i : instr_i.arg1;       // Second operand
  wire        cmp_lt = cmp_a < cmp_b;
  wire        cmp_ne = cmp_a != cmp_b;
  wire [15:0] pc3    = instr_i.pc + ccid_pkg::LEN_THREE;      // Next address
  // sign-extended displacement added to advanced address
  wire [15:0] cmp_tg = pc3 + {{8{instr_i.arg2[7]}}, instr_i.arg2};
  // Register form bit, work_reg vs immediate
  wire        c_rg   = op[3];
  wire        c_any  = c_im | c_dr | c_in | c_rg;             // Legal form

  // ********************************
  // Single-cycle datapath
  // ********************************
  // Length of the one-cycle opcodes; two bytes when an address follows
  wire [15:0] len   = (clr_b | inv_b | dec_d) ? ccid_pkg::LEN_TWO : ccid_pkg::LEN_ONE;
  wire [15:0] pc1   = instr_i.pc + len;                       // Next address
  wire [7:0]  bcd_a;                                          // Fixed accumulator
  wire        bcd_c;                                          // Fixed carry
  // port modify takes the output latch
  wire [7:0]  dec_s = (dec_d & is_port_i) ? latch_i : operand_i;
  wire        bit_s = is_port_i ? bit_latch_i : bit_i;        // Bit source
  // wraps 00 to FF, no flags
  wire [7:0]  dec_v = (dec_a ? ctx_i.acc : dec_s) - 8'h01;

  ccid_bcd_fix u_bcd (
    .acc_i       (ctx_i.acc),
    .carry_i     (ctx_i.carry),
    .nib_carry_i (ctx_i.nib_carry),
    .acc_o       (bcd_a),
    .carry_o     (bcd_c)
  );

  // ********************************
  // Next result
  // ********************************
  wire fin2 = state_q == ccid_pkg::CCID_CMP2; // Compare finishing
  wire [7:0] acc_n = clr_a ? 8'h00 : inv_a ? ~ctx_i.acc : bcd ? bcd_a : dec_v;
  wire       car_n = fin2 ? lt_q : inv_c ? ~ctx_i.carry : bcd ? bcd_c : 1'b0;

  always_comb
  begin
    res_d          = '0;
    res_d.done     = (go & ~cmp) | fin2;
    res_d.unknown  = go & unk;
    // Value fields stay zero unless written, so no stale data leaks out
    res_d.acc_we   = go & (clr_a | inv_a | bcd | dec_a);
    res_d.acc      = res_d.acc_we ? acc_n : 8'h00;
    res_d.carry_we = (go & (clr_c | inv_c | bcd)) | fin2;
    res_d.carry    = res_d.carry_we & car_n;
    res_d.byte_we  = go & dec_m;
    res_d.byte_v   = res_d.byte_we ? dec_v : 8'h00;
    res_d.bit_we   = go & (clr_b | inv_b);
    res_d.bit_v    = res_d.bit_we & inv_b & ~bit_s;
    res_d.branch   = fin2 & take_q;
    // Next address only while a result is presented
    if (res_d.done)
    begin
      res_d.pc     = fin2 ? (take_q ? tgt_q : fall_q) : pc1;
    end
    else
    begin
      res_d.pc     = 16'h0000;
    end
  end

  // Next state; compare holds the block for its second cycle
  always_comb
  begin
    case (state_q)
      ccid_pkg::CCID_IDLE:
        state_d = (go & cmp & c_any) ? ccid_pkg::CCID_CMP2 : ccid_pkg::CCID_IDLE;
      ccid_pkg::CCID_CMP2:
        state_d = ccid_pkg::CCID_IDLE;
      default:
        state_d = ccid_pkg::CCID_IDLE;
    endcase
  end

  // ********************************
  // Registers
  // ********************************
  // Sequencer and result flops
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state_q <= ccid_pkg::CCID_IDLE;
      res_q   <= '0;
      busy_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      res_q   <= res_d;
      busy_q  <= state_d == ccid_pkg::CCID_CMP2;
    end
  end

  // Compare outcome held for the second cycle, operands may change meanwhile
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      take_q <= 1'b0;
      lt_q   <= 1'b0;
      fall_q <= 16'h0000;
      tgt_q  <= 16'h0000;
    end
    else if (go & cmp)
    begin
      take_q <= cmp_ne;
      lt_q   <= cmp_lt;
      fall_q <= pc3;
      tgt_q  <= cmp_tg;
    end
  end

  assign res_o  = res_q;
  assign busy_o = busy_q;

  // ********************************
  // Assertions
  // ********************************
  a_cmp_two_cycles: assert property (@(posedge clock_i) disable iff (rst_i)
    go & cmp |=> !res_o.done ##1 res_o.done && res_o.carry_we)
    else $error("compare did not finish in two cycles");

  a_cmp_carry_lt: assert property (@(posedge clock_i) disable iff (rst_i)
    go & cmp |-> ##2 res_o.carry == $past(cmp_lt, 2))
    else $error("compare carry wrong");

  a_cmp_equal_fall: assert property (@(posedge clock_i) disable iff (rst_i)
    go & cmp & !cmp_ne |-> ##2 !res_o.branch && !res_o.carry
      && res_o.pc == $past(pc3, 2))
    else $error("equal compare branched");

  a_cmp_target: assert property (@(posedge clock_i) disable iff (rst_i)
    go & cmp & cmp_ne |-> ##2 res_o.branch && res_o.pc == $past(cmp_tg, 2))
    else $error("compare target wrong");

  a_clr_acc_zero: assert property (@(posedge clock_i) disable iff (rst_i)
    go & clr_a |=> res_o.done && res_o.acc_we && res_o.acc == 8'h00
      && !res_o.carry_we && res_o.pc == $past(instr_i.pc) + 16'h0001)
    else $error("accumulator zero fill wrong");

  a_clr_bit_len: assert property (@(posedge clock_i) disable iff (rst_i)
    go & clr_b |=> res_o.done && res_o.bit_we && !res_o.bit_v
      && res_o.pc == $past(instr_i.pc) + 16'h0002)
    else $error("bit zero fill wrong");

  a_inv_acc_value: assert property (@(posedge clock_i) disable iff (rst_i)
    go & inv_a |=> res_o.acc_we && res_o.acc == ~$past(ctx_i.acc) && !res_o.carry_we)
    else $error("accumulator invert wrong");

  a_inv_carry_flip: assert property (@(posedge clock_i) disable iff (rst_i)
    go & inv_c |=> res_o.carry_we && res_o.carry != $past(ctx_i.carry))
    else $error("carry invert wrong");

  a_bcd_keeps_carry: assert property (@(posedge clock_i) disable iff (rst_i)
    go & bcd & ctx_i.carry |=> res_o.done && res_o.carry_we && res_o.carry)
    else $error("BCD fix cleared carry");

  a_dec_port_latch: assert property (@(posedge clock_i) disable iff (rst_i)
    go & dec_d & is_port_i |=> res_o.byte_we && res_o.byte_v == $past(latch_i) - 8'h01)
    else $error("subtract one read pins for a port");

  a_dec_wraps_ff: assert property (@(posedge clock_i) disable iff (rst_i)
    go & dec_a & (ctx_i.acc == 8'h00) |=> res_o.acc == 8'hFF && !res_o.carry_we)
    else $error("subtract one did not wrap");
endmodule

/* inc/ccid_pkg.sv */
// Package for the compare, clear, invert, BCD fix and subtract-one slice.
// Assumes the surrounding core fetches operands and writes results back.
package ccid_pkg;

  // ********************************
  // Opcodes
  // ********************************
  localparam logic [7:0] OP_CLR_A   = 8'hE4; // Zero fill accumulator
  localparam logic [7:0] OP_CLR_C   = 8'hC3; // Zero fill carry
  localparam logic [7:0] OP_CLR_BIT = 8'hC2; // Zero fill addressed bit
  localparam logic [7:0] OP_INV_A   = 8'hF4; // Invert accumulator
  localparam logic [7:0] OP_INV_C   = 8'hB3; // Invert carry
  localparam logic [7:0] OP_INV_BIT = 8'hB2; // Invert addressed bit
  localparam logic [7:0] OP_BCD     = 8'hD4; // BCD nibble fix
  localparam logic [7:0] OP_DEC_A   = 8'h14; // Subtract one, accumulator
  localparam logic [7:0] OP_DEC_DIR = 8'h15; // Subtract one, direct byte
  localparam logic [7:0] OP_DEC_IND = 8'h16; // Subtract one, pointer_reg, low bit i
  localparam logic [7:0] OP_DEC_REG = 8'h18; // Subtract one, work_reg, low bits rrr

  // ********************************
  // Compare-branch-unequal forms
  // ********************************
  localparam logic [3:0] CMP_HI   = 4'hB; // Shared upper nibble
  localparam logic [3:0] CMP_IMM  = 4'h4; // Accumulator vs immediate
  localparam logic [3:0] CMP_DIR  = 4'h5; // Accumulator vs direct
  localparam logic [2:0] CMP_IND  = 3'h3; // 011i, pointer_reg vs immediate

  // ********************************
  // Lengths and BCD constants
  // ********************************
  localparam logic [15:0] LEN_ONE   = 16'h0001; // One-byte opcodes
  localparam logic [15:0] LEN_TWO   = 16'h0002; // Opcode plus address
  localparam logic [15:0] LEN_THREE = 16'h0003; // Compare forms
  localparam logic [3:0]  BCD_NINE  = 4'h9;     // Largest decimal digit
  localparam logic [8:0]  BCD_LO6   = 9'h006;   // Low digit correction
  localparam logic [8:0]  BCD_HI6   = 9'h060;   // High digit correction

  // ********************************
  // Types
  // ********************************
  typedef enum logic [1:0] {
    CCID_IDLE = 2'b00, // Ready for an instruction
    CCID_CMP2 = 2'b01  // Second cycle of a compare
  } ccid_state_t;

  typedef struct packed {
    logic [7:0]  opcode; // First instruction byte
    logic [7:0]  arg1;   // Second byte: address, bit or immediate
    logic [7:0]  arg2;   // Third byte: displacement
    logic [15:0] pc;     // Address of the opcode byte
  } ccid_instr_t;

  typedef struct packed {
    logic [7:0] acc;       // Accumulator
    logic       carry;     // Carry flag
    logic       nib_carry; // nibble_carry_flag
  } ccid_ctx_t;

  typedef struct packed {
    logic        done;     // Instruction finished
    logic        unknown;  // Opcode outside this slice
    logic        acc_we;   // Write accumulator
    logic [7:0]  acc;      // New accumulator
    logic        carry_we; // Write carry
    logic        carry;    // New carry
    logic        byte_we;  // Write addressed byte
    logic [7:0]  byte_v;   // New byte value
    logic        bit_we;   // Write addressed bit
    logic        bit_v;    // New bit value
    logic        branch;   // Branch taken
    logic [15:0] pc;       // Next program_counter
  } ccid_res_t;

endpackage

/* rtl/ccid_bcd_fix.sv */
// BCD nibble fix datapath, purely combinational.
// Assumes the caller registers the result.
`timescale 1ns/1ns
module ccid_bcd_fix (
  input  wire logic [7:0] acc_i,       // Accumulator before the fix
  input  wire logic       carry_i,     // Carry before the fix
  input  wire logic       nib_carry_i, // nibble_carry_flag
  output logic      [7:0] acc_o,       // Fixed accumulator
  output logic            carry_o      // Carry after the fix
);
  // ********************************
  // Low digit step
  // ********************************
  // low nibble correction
  wire       lo_fix = (acc_i[3:0] > ccid_pkg::BCD_NINE) | nib_carry_i;
  wire [8:0] lo_sum = {1'b0, acc_i} + (lo_fix ? ccid_pkg::BCD_LO6 : 9'h000);
  // Carry after the first step, never cleared
  wire       c_mid  = carry_i | lo_sum[8];

  // ********************************
  // High digit step
  // ********************************
  // high nibble correction
  wire       hi_fix = (lo_sum[7:4] > ccid_pkg::BCD_NINE) | c_mid;
  wire [8:0] hi_sum = {1'b0, lo_sum[7:0]} + (hi_fix ? ccid_pkg::BCD_HI6 : 9'h000);

  assign carry_o = c_mid | hi_sum[8];
  assign acc_o   = hi_sum[7:0];
endmodule

/* test/ccid_exec_tb.sv */
// Self-checking bench for the compare, clear, invert, BCD fix and
// subtract-one slice. Assumes ccid_pkg is compiled first.
`timescale 1ns/1ns
module ccid_exec_tb;
  // ************************************
  // Signals
  // ************************************
  localparam logic [15:0] PC0 = 16'h1000; // Opcode address of every test
  logic                  clock_i;     // 10 MHz core clock
  logic                  rst_i;       // Synchronous reset
  logic                  issue_i;     // Issue strobe
  ccid_pkg::ccid_instr_t instr_i;     // Instruction bytes
  ccid_pkg::ccid_ctx_t   ctx_i;       // Accumulator and flags
  logic [7:0]            operand_i;   // Operand as read
  logic [7:0]            latch_i;     // Port latch byte
  logic                  is_port_i;   // Address is a port
  logic                  bit_i;       // Bit as read
  logic                  bit_latch_i; // Bit port latch
  logic                  busy_o;      // Compare busy
  ccid_pkg::ccid_res_t   res_o;       // Result
  ccid_pkg::ccid_res_t   r;           // Captured result
  logic                  busy1;       // Busy seen one cycle after issue
  int                    n_mismatch;
  int                    n_checks;
  int                    lat_n;       // Cycles from issue edge to answer

  // Half period of 50 ns
  always #50 clock_i = ~clock_i;

  ccid_exec i_ccid_exec (
    .clock_i(clock_i), .rst_i(rst_i), .issue_i(issue_i), .instr_i(instr_i),
    .ctx_i(ctx_i), .operand_i(operand_i), .latch_i(latch_i),
    .is_port_i(is_port_i), .bit_i(bit_i), .bit_latch_i(bit_latch_i),
    .busy_o(busy_o), .res_o(res_o)
  );

  // ************************************
  // Compare helpers
  // ************************************
  task automatic chk_res(input string nm, input ccid_pkg::ccid_res_t ex, got);
    n_checks++;
    if (ex !== got)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic chk_bit(input string nm, input logic ex, got);
    n_checks++;
    if (ex !== got)
    begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", nm, ex, got);
    end
  endtask

  // Expected result with done raised
  function automatic ccid_pkg::ccid_res_t mk(input logic aw, input logic [7:0] a,
    input logic cw, c, bw, input logic [7:0] bv, input logic tw, tv, br,
    input logic [15:0] pc);
    mk = '{done: 1'b1, unknown: 1'b0, acc_we: aw, acc: a, carry_we: cw, carry: c,
      byte_we: bw, byte_v: bv, bit_we: tw, bit_v: tv, branch: br, pc: pc};
  endfunction

  // One issue, then a bounded wait for done or unknown
  task automatic go(input logic [7:0] op, a1, a2, acc, input logic c, nc,
    input logic [7:0] opnd, lt, input logic port, b, bl);
    @(posedge clock_i);
    issue_i   <= 1'b1;
    instr_i   <= '{opcode: op, arg1: a1, arg2: a2, pc: PC0};
    ctx_i     <= '{acc: acc, carry: c, nib_carry: nc};
    operand_i <= opnd;
    latch_i   <= lt;
    is_port_i <= port;
    bit_i     <= b;
    bit_latch_i <= bl;
    @(posedge clock_i);
    issue_i <= 1'b0;
    #1;
    lat_n = 1;
    busy1 = busy_o;
    while (res_o.done !== 1'b1 && res_o.unknown !== 1'b1 && lat_n < 6)
    begin
      @(posedge clock_i);
      #1;
      lat_n++;
    end
    r = res_o;
  endtask

  // ************************************
  // Scenarios
  // ************************************
  task automatic cmp_one(input logic [7:0] op, acc, imm, opnd, d);
    logic [7:0]  f;
    logic [7:0]  s;
    logic [15:0] pc;
    f  = (op == 8'hB4 || op == 8'hB5) ? acc : opnd;
    s  = (op == 8'hB5) ? opnd : imm;
    pc = (f != s) ? PC0 + 16'h0003 + {{8{d[7]}}, d} : PC0 + 16'h0003;
    go(op, imm, d, acc, ~(f < s), 1'b0, opnd, ~opnd, 1'b0, 1'b0, 1'b0);
    chk_bit("cmp_busy", 1'b1, busy1);
    chk_bit("cmp_two_cycles", 1'b1, lat_n == 2);
    chk_res("cmp", mk(0, 8'h00, 1, f < s, 0, 8'h00, 0, 0, f != s, pc), r);
  endtask

  task automatic t_compare;
    cmp_one(8'hB4, 8'h34, 8'h34, 8'h99, 8'h10);
    cmp_one(8'hB5, 8'h10, 8'h00, 8'h20, 8'hF0);
    cmp_one(8'hB6, 8'h00, 8'h7F, 8'h80, 8'h05);
    cmp_one(8'hB7, 8'h00, 8'hFF, 8'h00, 8'h7F);
    for (int i = 0; i < 8; i++)
      cmp_one(8'hB8 + 8'(i), 8'h00, 8'h43, 8'h40 + 8'(i), 8'h02);
    $display("compare done");
  endtask

  task automatic t_clear_invert;
    go(8'hE4, 8'h00, 8'h00, 8'h5C, 1, 1, 8'h00, 8'h00, 0, 0, 0);
    chk_res("clr_acc", mk(1, 8'h00, 0, 0, 0, 8'h00, 0, 0, 0, PC0 + 16'h0001), r);
    go(8'hC3, 8'h00, 8'h00, 8'h5C, 1, 0, 8'h00, 8'h00, 0, 0, 0);
    chk_res("clr_c", mk(0, 8'h00, 1, 0, 0, 8'h00, 0, 0, 0, PC0 + 16'h0001), r);
    go(8'hC2, 8'h92, 8'h00, 8'h00, 1, 0, 8'h00, 8'h00, 1, 1, 1);
    chk_res("clr_bit", mk(0, 8'h00, 0, 0, 0, 8'h00, 1, 0, 0, PC0 + 16'h0002), r);
    go(8'hF4, 8'h00, 8'h00, 8'h5C, 1, 1, 8'h00, 8'h00, 0, 0, 0);
    chk_res("inv_acc", mk(1, 8'hA3, 0, 0, 0, 8'h00, 0, 0, 0, PC0 + 16'h0001), r);
    for (int i = 0; i < 2; i++)
    begin
      go(8'hB3, 8'h00, 8'h00, 8'h00, i[0], 0, 8'h00, 8'h00, 0, 0, 0);
      chk_res("inv_c", mk(0, 8'h00, 1, ~i[0], 0, 8'h00, 0, 0, 0, PC0 + 16'h0001), r);
      go(8'hB2, 8'h91, 8'h00, 8'h00, 0, 0, 8'h00, 8'h00, i[0], 1, 0);
      chk_res("inv_bit", mk(0, 8'h00, 0, 0, 0, 8'h00, 1, i[0], 0, PC0 + 16'h0002), r);
    end
    $display("clear and invert done");
  endtask

  task automatic t_bcd;
    logic [8:0] t;
    logic [7:0] a [5] = '{8'hBE, 8'h12, 8'h9A, 8'h38, 8'h56};
    logic       c;
    for (int i = 0; i < 5; i++)
    begin
      c = (i == 1);
      t = {1'b0, a[i]};
      if (t[3:0] > 4'h9 || i == 3)
        t = t + 9'h006;
      c = c | t[8];
      t[8] = 1'b0;
      if (t[7:4] > 4'h9 || c)
        t = t + 9'h060;
      c = c | t[8];
      go(8'hD4, 8'h00, 8'h00, a[i], i == 1, i == 3, 8'h00, 8'h00, 0, 0, 0);
      r.carry = r.carry_we ? r.carry : (i == 1);
      r.carry_we = 1'b1;
      chk_res("bcd", mk(1, t[7:0], 1, c, 0, 8'h00, 0, 0, 0, PC0 + 16'h0001), r);
    end
    $display("bcd fix done");
  endtask

  task automatic t_dec;
    go(8'h14, 8'h00, 8'h00, 8'h00, 1, 1, 8'h00, 8'h00, 0, 0, 0);
    chk_res("dec_acc", mk(1, 8'hFF, 0, 0, 0, 8'h00, 0, 0, 0, PC0 + 16'h0001), r);
    for (int i = 0; i < 10; i++)
    begin
      go(8'h16 + 8'(i), 8'h00, 8'h00, 8'h00, 0, 0, 8'(i), 8'hAA, 0, 0, 0);
      chk_res("dec_byte", mk(0, 8'h00, 0, 0, 1, 8'(i) - 8'h01, 0, 0, 0,
        PC0 + 16'h0001), r);
    end
    go(8'h15, 8'h30, 8'h00, 8'h00, 0, 0, 8'h00, 8'h55, 0, 0, 0);
    chk_res("dec_dir", mk(0, 8'h00, 0, 0, 1, 8'hFF, 0, 0, 0, PC0 + 16'h0002), r);
    go(8'h15, 8'h90, 8'h00, 8'h00, 0, 0, 8'h00, 8'h10, 1, 0, 0);
    chk_res("dec_port", mk(0, 8'h00, 0, 0, 1, 8'h0F, 0, 0, 0, PC0 + 16'h0002), r);
    go(8'h00, 8'h00, 8'h00, 8'h00, 0, 0, 8'h00, 8'h00, 0, 0, 0);
    chk_bit("unknown", 1'b1, r.unknown);
    chk_bit("unknown_done", 1'b1, r.done);
    $display("subtract one done");
  endtask

  // ************************************
  // Run control
  // ************************************
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard, far beyond the roughly 90 cycles the tests need
  initial
  begin
    repeat (3000) @(posedge clock_i);
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    clock_i = 1'b0;
    rst_i = 1'b1;
    issue_i = 1'b0;
    instr_i = '0;
    ctx_i = '0;
    operand_i = 8'h00;
    latch_i = 8'h00;
    is_port_i = 1'b0;
    bit_i = 1'b0;
    bit_latch_i = 1'b0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    #1;
    chk_res("reset_res", '0, res_o);
    chk_bit("reset_busy", 1'b0, busy_o);
    t_compare();
    t_clear_invert();
    t_bcd();
    t_dec();
    wrap_up();
  end
endmodule
